// *** logic/rcrb_pkg.sv ***
// Purpose: Shared constants and types for the rail control register bank
// Assumes: Byte-wide registers behind the serial management interface
// Notes:   Factory values arrive from the one-time-programmable image at power-up
package rcrb_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_CONV4 = 8'h25;
	localparam logic [7:0] ADDR_CONV5 = 8'h26;
	localparam logic [7:0] ADDR_CONV6 = 8'h27;
	localparam logic [7:0] ADDR_LIN_A2 = 8'h28;
	localparam logic [7:0] ADDR_LIN_A3 = 8'h29;
	localparam logic [7:0] ADDR_DISCH1 = 8'h40;

	// Slots: rails 0..4 in the order above, then the discharge register
	localparam int         NUM_RAILS  = 5;
	localparam int         NUM_CONV   = 3;
	localparam logic [2:0] SLOT_DISCH = 3'h5;
	localparam logic [2:0] SLOT_NONE  = 3'h7;
	localparam logic [2:0] OTP_LAST   = 3'h5;

	// Field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_MODE   = 1;
	localparam int NUM_DFIELD = 4;

	// Reset values and masks
	localparam logic [7:0] CTRL_RESET    = 8'h3D;
	localparam logic [7:0] DISCH_RESET   = 8'h55;
	localparam logic [7:0] CTRL_WR_MASK  = 8'h3F;
	localparam logic [7:0] CTRL_SLEEP    = 8'h3C;
	localparam logic [7:0] CONV_OTP_MASK = 8'h03;
	localparam logic [7:0] LIN_OTP_MASK  = 8'h01;
	localparam logic [7:0] RDATA_IDLE    = 8'h00;

	typedef enum logic [1:0] {
		DISCH_NONE = 2'h0,
		DISCH_100R = 2'h1,
		DISCH_200R = 2'h2,
		DISCH_500R = 2'h3
	} rcrb_disch_t;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b001,
		ST_STORE = 3'b010,
		ST_READY = 3'b100
	} rcrb_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rcrb_req_t;

endpackage

// *** logic/rcrb_ctrl_reg.sv ***
// Purpose: One rail control register with factory load and host write
// Assumes: Load and write never coincide; load only happens before host access opens
// Notes:   Top two bits are held at zero so reads return zero there
`timescale 1ns/1ps
module rcrb_ctrl_reg #(
	parameter logic [7:0] RESET_VAL = rcrb_pkg::CTRL_RESET
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       load_en,
	input  wire logic [7:0] load_val,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_val,
	output logic      [7:0] value
);

	logic [7:0] next_value;

	always_comb begin
		next_value = value;
		if (load_en) begin
			next_value = load_val;
		end else if (wr_en) begin
			next_value = wr_val;
		end
		next_value = next_value & rcrb_pkg::CTRL_WR_MASK;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			value <= RESET_VAL;
		end else begin
			value <= next_value;
		end
	end

endmodule

// *** logic/rcrb_bank.sv ***
// Purpose: Rail control and first discharge selection registers
// Assumes: Host requests and rail status inputs share sys_clk; control pins are async
// Notes:   Host access is refused until the factory image has been loaded
`timescale 1ns/1ps
// Operation
// - Control bit 1 picks auto or forced PWM
// - Enable bit 0 low forces rail off
// - Control bits 7:6 read zero, ignore writes
// - Rail that is on clears its discharge field
// - Discharge register holds four fields, default 01
// - Linear regulators have enable only, no mode
// - Discharge codes select none, 100, 200, 500 ohms
module rcrb_bank #(
	parameter logic [29:0] RAIL_PIN_MAP = 30'h0104_1041
) (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire rcrb_pkg::rcrb_req_t reg_req,
	output logic                    reg_ack,
	output logic              [7:0] reg_rdata,
	output logic                    reg_ready,
	output logic              [2:0] otp_index,
	input  wire logic         [7:0] otp_data,
	input  wire logic         [5:0] external_rail_control_pins,
	input  wire logic               conv1_rail_on,
	input  wire logic               conv2_rail_on,
	input  wire logic               conv3_rail_on,
	output logic              [4:0] rail_on,
	output logic                    conv4_switching_mode,
	output logic                    conv5_switching_mode,
	output logic                    conv6_switching_mode,
	output logic                    conv4_run_enable,
	output logic                    conv5_run_enable,
	output logic                    conv6_run_enable,
	output logic                    linear_a2_run_enable,
	output logic                    linear_a3_run_enable,
	output logic              [1:0] conv1_discharge_sel,
	output logic              [1:0] conv2_discharge_sel,
	output logic              [1:0] conv3_discharge_sel,
	output logic              [1:0] conv4_discharge_sel,
	output logic              [3:0] conv_discharge_active
);

	function automatic logic [2:0] addr_slot(input logic [7:0] addr);
		unique case (addr)
			rcrb_pkg::ADDR_CONV4:  addr_slot = 3'h0;
			rcrb_pkg::ADDR_CONV5:  addr_slot = 3'h1;
			rcrb_pkg::ADDR_CONV6:  addr_slot = 3'h2;
			rcrb_pkg::ADDR_LIN_A2: addr_slot = 3'h3;
			rcrb_pkg::ADDR_LIN_A3: addr_slot = 3'h4;
			rcrb_pkg::ADDR_DISCH1: addr_slot = rcrb_pkg::SLOT_DISCH;
			default:               addr_slot = rcrb_pkg::SLOT_NONE;
		endcase
	endfunction

	function automatic logic pin_request(input logic [5:0] pins, input logic [5:0] map);
		pin_request = |(pins & map);
	endfunction

	rcrb_pkg::rcrb_state_t state;
	rcrb_pkg::rcrb_state_t next_state;
	logic [2:0] next_otp_index;
	logic       next_ready;
	logic       next_ack;
	logic [7:0] next_rdata;
	logic [7:0] disch;
	logic [7:0] next_disch;
	logic [4:0] next_rail_on;
	logic [3:0] next_active;
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic [5:0] next_pin_meta;
	logic [5:0] next_pin_sync;
	logic [7:0] ctrl_val [0:4];
	logic [3:0] field_on;
	logic [2:0] req_slot;
	logic       host_wr;
	logic       storing;

	assign req_slot = addr_slot(reg_req.addr);
	assign host_wr  = reg_ready && reg_req.wr;
	assign storing  = (state == rcrb_pkg::ST_STORE);

	// Converters keep mode and enable from the image; linear ones only enable
	genvar gi;
	generate
		for (gi = 0; gi < rcrb_pkg::NUM_RAILS; gi++) begin : g_rail
			localparam logic [7:0] OTP_MASK = (gi < rcrb_pkg::NUM_CONV) ?
				rcrb_pkg::CONV_OTP_MASK : rcrb_pkg::LIN_OTP_MASK;
			rcrb_ctrl_reg #(
				.RESET_VAL (rcrb_pkg::CTRL_RESET)
			) u_ctrl (
				.sys_clk  (sys_clk),
				.rst      (rst),
				.load_en  (storing && (otp_index == 3'(gi))),
				.load_val (rcrb_pkg::CTRL_SLEEP | (otp_data & OTP_MASK)),
				.wr_en    (host_wr && (req_slot == 3'(gi))),
				.wr_val   (reg_req.wdata),
				.value    (ctrl_val[gi])
			);
			// Enable low wins over every pin request
			assign next_rail_on[gi] = ctrl_val[gi][rcrb_pkg::BIT_ENABLE] &&
				pin_request(pin_sync, RAIL_PIN_MAP[gi*6 +: 6]);
		end
	endgenerate

	assign field_on = {rail_on[0], conv3_rail_on, conv2_rail_on, conv1_rail_on};

	always_comb begin
		next_state     = state;
		next_otp_index = otp_index;
		next_ready     = reg_ready;
		next_ack       = 1'b0;
		next_rdata     = reg_rdata;
		next_disch     = disch;
		next_pin_meta  = external_rail_control_pins;
		next_pin_sync  = pin_meta;
		unique case (state)
			rcrb_pkg::ST_FETCH: begin
				next_state = rcrb_pkg::ST_STORE;
			end
			rcrb_pkg::ST_STORE: begin
				if (otp_index == rcrb_pkg::SLOT_DISCH) begin
					next_disch = otp_data;
				end
				if (otp_index == rcrb_pkg::OTP_LAST) begin
					next_state = rcrb_pkg::ST_READY;
					next_ready = 1'b1;
				end else begin
					next_state     = rcrb_pkg::ST_FETCH;
					next_otp_index = otp_index + 3'h1;
				end
			end
			rcrb_pkg::ST_READY: begin
				next_ack = reg_req.wr || reg_req.rd;
				if (host_wr && req_slot == rcrb_pkg::SLOT_DISCH) begin
					next_disch = reg_req.wdata;
				end
				if (reg_req.rd) begin
					if (req_slot == rcrb_pkg::SLOT_DISCH) begin
						next_rdata = disch;
					end else if (req_slot == rcrb_pkg::SLOT_NONE) begin
						next_rdata = rcrb_pkg::RDATA_IDLE;
					end else begin
						next_rdata = ctrl_val[req_slot];
					end
				end
			end
		endcase
		// Clearing after the write means a write can never load the field of a rail that is on
		for (int f = 0; f < rcrb_pkg::NUM_DFIELD; f++) begin
			if (field_on[f]) begin
				next_disch[2*f +: 2] = rcrb_pkg::DISCH_NONE;
			end
			next_active[f] = (disch[2*f +: 2] != rcrb_pkg::DISCH_NONE);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state                 <= rcrb_pkg::ST_FETCH;
			otp_index             <= 3'h0;
			reg_ready             <= 1'b0;
			reg_ack               <= 1'b0;
			reg_rdata             <= rcrb_pkg::RDATA_IDLE;
			disch                 <= rcrb_pkg::DISCH_RESET;
			rail_on               <= 5'h00;
			conv_discharge_active <= 4'h0;
			pin_meta              <= 6'h00;
			pin_sync              <= 6'h00;
		end else begin
			state                 <= next_state;
			otp_index             <= next_otp_index;
			reg_ready             <= next_ready;
			reg_ack               <= next_ack;
			reg_rdata             <= next_rdata;
			disch                 <= next_disch;
			rail_on               <= next_rail_on;
			conv_discharge_active <= next_active;
			pin_meta              <= next_pin_meta;
			pin_sync              <= next_pin_sync;
		end
	end

	// The sleep bits 5:2 are stored as written; software must keep them set
	assign conv4_switching_mode = ctrl_val[0][rcrb_pkg::BIT_MODE];
	assign conv5_switching_mode = ctrl_val[1][rcrb_pkg::BIT_MODE];
	assign conv6_switching_mode = ctrl_val[2][rcrb_pkg::BIT_MODE];
	assign conv4_run_enable     = ctrl_val[0][rcrb_pkg::BIT_ENABLE];
	assign conv5_run_enable     = ctrl_val[1][rcrb_pkg::BIT_ENABLE];
	assign conv6_run_enable     = ctrl_val[2][rcrb_pkg::BIT_ENABLE];
	assign linear_a2_run_enable = ctrl_val[3][rcrb_pkg::BIT_ENABLE];
	assign linear_a3_run_enable = ctrl_val[4][rcrb_pkg::BIT_ENABLE];
	assign conv1_discharge_sel  = disch[1:0];
	assign conv2_discharge_sel  = disch[3:2];
	assign conv3_discharge_sel  = disch[5:4];
	assign conv4_discharge_sel  = disch[7:6];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic last_ctrl_rd;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last_ctrl_rd <= 1'b0;
		end else begin
			last_ctrl_rd <= reg_req.rd && (req_slot < rcrb_pkg::SLOT_DISCH);
		end
	end

	sequence s_load_start;
		$fell(rst);
	endsequence
	sequence s_load_done;
		##[1:16] reg_ready;
	endsequence

	chk_mode_write: assert property (host_wr && req_slot == 3'h0 |=>
		conv4_switching_mode == $past(reg_req.wdata[1]))
		else $error("conv4 mode did not follow write");
	chk_enable_off: assert property (!conv5_run_enable |=> !rail_on[1])
		else $error("disabled rail still on");
	chk_upper_zero: assert property (reg_ack && last_ctrl_rd |-> reg_rdata[7:6] == 2'h0)
		else $error("control upper bits not zero");
	chk_disch_clear: assert property (conv1_rail_on |=> conv1_discharge_sel == 2'h0)
		else $error("enabled rail kept discharge");
	chk_disch_write: assert property (host_wr && req_slot == rcrb_pkg::SLOT_DISCH &&
		!rail_on[0] |=> conv4_discharge_sel == $past(reg_req.wdata[7:6]))
		else $error("conv4 discharge field misplaced");
	chk_linear_mode: assert property (host_wr && req_slot == 3'h3 |=>
		$stable(conv4_switching_mode) && $stable(conv6_switching_mode))
		else $error("linear write changed a mode");
	chk_load_apply: assert property (1'b1 |=>
		conv_discharge_active[3] == ($past(conv4_discharge_sel) != rcrb_pkg::DISCH_NONE))
		else $error("discharge load not applied");
	chk_no_early_ack: assert property (!reg_ready |=> !reg_ack)
		else $error("access answered before load");
	chk_load_bound: assert property (s_load_start |-> s_load_done)
		else $error("factory load did not finish");

endmodule

// *** verif/rcrb_otp_model.sv ***
// Purpose: Factory image source answering the bank's fetch index
// Assumes: Data follows the index by one registered cycle
// Notes:   Indices past the image give a toggling pattern, never a stale byte
`timescale 1ns/1ps
module rcrb_otp_model #(
	parameter logic [47:0] IMAGE = 48'h0000_0000_0000
) (
	input  wire logic       sys_clk,
	input  wire logic [2:0] otp_index,
	output logic      [7:0] otp_data
);
	logic [7:0] junk = 8'h5A;

	always_ff @(posedge sys_clk) begin
		junk <= ~junk;
		if (otp_index <= rcrb_pkg::OTP_LAST) begin
			otp_data <= IMAGE[otp_index*8 +: 8];
		end else begin
			otp_data <= junk;
		end
	end
endmodule

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the rail control register bank
// Assumes: Every rail mapped to pin bit 0 by the default pin map
// Notes:   Random writes outside the discharge register keep bits 5:2 set, as software must
`timescale 1ns/1ps
module testbench;
	localparam logic [47:0] IMG = 48'hE400_0301_0302;
	logic                 sys_clk = 1'b0;
	logic                 rst     = 1'b1;
	rcrb_pkg::rcrb_req_t  reg_req = '0;
	logic                 reg_ack, reg_ready;
	logic           [7:0] reg_rdata, otp_data, rd, d;
	logic           [2:0] otp_index;
	logic           [5:0] pins = 6'h00;
	logic           [2:0] conv_on = 3'h0;
	logic           [4:0] rail_on;
	logic           [2:0] mode;
	logic           [4:0] en;
	logic           [7:0] dsel;
	logic           [3:0] act;
	logic           [7:0] mir [0:5];
	logic           [7:0] addrs [0:6];
	int                   fail_count = 0;
	int                   num_checks = 0;
	int                   cycles = 0;
	int                   s;

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	rcrb_otp_model #(.IMAGE(IMG)) otp (.sys_clk(sys_clk), .otp_index(otp_index),
		.otp_data(otp_data));

	rcrb_bank DUT (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_ack(reg_ack),
		.reg_rdata(reg_rdata), .reg_ready(reg_ready), .otp_index(otp_index),
		.otp_data(otp_data), .external_rail_control_pins(pins),
		.conv1_rail_on(conv_on[0]), .conv2_rail_on(conv_on[1]), .conv3_rail_on(conv_on[2]),
		.rail_on(rail_on), .conv4_switching_mode(mode[0]), .conv5_switching_mode(mode[1]),
		.conv6_switching_mode(mode[2]), .conv4_run_enable(en[0]), .conv5_run_enable(en[1]),
		.conv6_run_enable(en[2]), .linear_a2_run_enable(en[3]),
		.linear_a3_run_enable(en[4]), .conv1_discharge_sel(dsel[1:0]),
		.conv2_discharge_sel(dsel[3:2]), .conv3_discharge_sel(dsel[5:4]),
		.conv4_discharge_sel(dsel[7:6]), .conv_discharge_active(act));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// One request, held until the answer edge; ack stands a single cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
		@(posedge sys_clk);
		reg_req <= '{wr: w, rd: ~w, addr: a, wdata: wd};
		@(posedge sys_clk);
		reg_req <= '0;
		#1;
		check({7'h0, reg_ack}, 8'h01);
		rd = reg_rdata;
	endtask

	// Expected readback: ctrl bits 7:6 always zero
	function automatic logic [7:0] exp_rd(input int k);
		return (k == 6) ? 8'h00 : (k == 5) ? mir[5] : (mir[k] & 8'h3F);
	endfunction

	task automatic check_outs();
		for (int k = 0; k < 3; k++) check({7'h0, mode[k]}, {7'h0, mir[k][1]});
		for (int k = 0; k < 5; k++) check({7'h0, en[k]}, {7'h0, mir[k][0]});
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			results();
		end
	end

	initial begin
		void'($urandom(54));
		addrs = '{rcrb_pkg::ADDR_CONV4, rcrb_pkg::ADDR_CONV5, rcrb_pkg::ADDR_CONV6,
			rcrb_pkg::ADDR_LIN_A2, rcrb_pkg::ADDR_LIN_A3, rcrb_pkg::ADDR_DISCH1, 8'h30};
		for (int k = 0; k < 6; k++) begin
			d = IMG[k*8 +: 8];
			mir[k] = (k == 5) ? d : 8'h3C | (d & ((k < 3) ? 8'h03 : 8'h01));
		end
		repeat (6) @(posedge sys_clk);
		rst     <= 1'b0;
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: rcrb_pkg::ADDR_CONV4, wdata: 8'h3C};
		repeat (3) begin
			@(posedge sys_clk);
			#1;
			check({7'h0, reg_ack}, 8'h00);
		end
		reg_req <= '0;
		for (int i = 0; i < 20 && reg_ready !== 1'b1; i++) @(posedge sys_clk);
		check({7'h0, reg_ready}, 8'h01);
		for (int k = 0; k < 7; k++) begin
			bus(1'b0, addrs[k], 8'h00);
			check(rd, exp_rd(k));
		end
		check_outs();
		check(dsel, mir[5]);
		for (int n = 0; n < 60; n++) begin
			s = (n < 7) ? n : $urandom_range(6);
			d = 8'($urandom());
			if (n == 6) d = 8'hFF;
			if (s < 5 || s == 6) d = d | 8'h3C;
			bus(1'b1, addrs[s], d);
			if (s < 6) mir[s] = d;
			check_outs();
			check(dsel, mir[5]);
			bus(1'b0, addrs[s], 8'h00);
			check(rd, exp_rd(s));
			for (int f = 0; f < 4; f++) check({7'h0, act[f]}, {7'h0, |mir[5][2*f +: 2]});
		end
		bus(1'b1, rcrb_pkg::ADDR_CONV4, 8'h3D);
		mir[0] = 8'h3D;
		pins <= 6'h01;
		repeat (4) @(posedge sys_clk);
		#1;
		check({3'h0, rail_on}, {3'h0, mir[4][0], mir[3][0], mir[2][0], mir[1][0], 1'b1});
		check({6'h0, dsel[7:6]}, 8'h00);
		conv_on <= 3'h7;
		repeat (3) @(posedge sys_clk);
		bus(1'b1, rcrb_pkg::ADDR_DISCH1, 8'hFF);
		bus(1'b0, rcrb_pkg::ADDR_DISCH1, 8'h00);
		check(rd, 8'h00);
		bus(1'b1, rcrb_pkg::ADDR_CONV4, 8'h3C);
		conv_on <= 3'h0;
		repeat (4) @(posedge sys_clk);
		#1;
		check({7'h0, rail_on[0]}, 8'h00);
		bus(1'b1, rcrb_pkg::ADDR_DISCH1, 8'hFF);
		check(dsel, 8'hFF);
		results();
	end
endmodule
